// ==== rtl/memory_bank_ctrl_parity_status.sv ====
// Bank strobe, parity and error status logic of the memory controller
// Assumes one clock for masters, memory and the AXI4-Lite register bus
`timescale 1ns/1ps
`include "mem_bank_map.svh"
module memory_bank_ctrl_parity_status
  import mem_bank_pkg::*;
#(
  parameter int NUM_BANKS = 8,
  parameter int ROW_SHIFT = 12
)
(
  // Clock and reset
  input  logic        aclk,
  input  logic        aresetn,
  // AXI4-Lite write channels
  input  logic [11:0] awaddr,
  input  logic        awvalid,
  output logic        awready,
  input  logic [31:0] wdata,
  input  logic [3:0]  wstrb,
  input  logic        wvalid,
  output logic        wready,
  output logic [1:0]  bresp,
  output logic        bvalid,
  input  logic        bready,
  // AXI4-Lite read channels
  input  logic [11:0] araddr,
  input  logic        arvalid,
  output logic        arready,
  output logic [31:0] rdata,
  output logic [1:0]  rresp,
  output logic        rvalid,
  input  logic        rready,
  // Internal master
  input  logic        int_req,
  input  mem_req_s    int_cmd,
  output logic        int_ready,
  output logic        int_done,
  output logic        int_bus_error,
  output logic [31:0] int_rdata,
  // External master pins
  input  logic        address_strobe_n,
  input  logic        transfer_start_n,
  input  mem_req_s    ext_cmd,
  // Memory side
  input  logic [31:0] mem_rdata,
  input  logic [3:0]  mem_rpar,
  output mem_pins_s   mem,
  output logic        parity_error_output
);
  if (NUM_BANKS < 1 || NUM_BANKS > 8 || ROW_SHIFT < 1 || ROW_SHIFT > 31)
  begin : g_bad
    $error("bank count must be 1..8 and row shift 1..31");
  end

  // Register file
  logic [`MB_MODE_W-1:0] mode_q;
  logic [`MB_ST_W-1:0]   st_q, st_d, st_set, st_clr;
  logic [7:0]            type_q;
  logic [31:0]           region_q [NUM_BANKS];
  mode_s                 m;
  assign m = mode_s'(mode_q);

  // Bus slave state
  logic        aw_have_q, w_have_q, bvalid_q, rvalid_q;
  logic [11:0] aw_addr_q;
  logic [31:0] w_data_q, rdata_q, rd_mux, wmask;
  logic [3:0]  w_strb_q, wr_code, rd_code;
  logic [1:0]  bresp_q, rresp_q;
  logic        wr_fire, rd_fire;

  // Register decode: 0 mode, 1 status, 2 type, 8+n region n, f none
  function automatic logic [3:0] decode_off(input logic [11:0] a);
    decode_off = 4'hf;
    if (a == `MB_OFF_MODE)
      decode_off = 4'h0;
    else if (a == `MB_OFF_STATUS)
      decode_off = 4'h1;
    else if (a == `MB_OFF_TYPE)
      decode_off = 4'h2;
    else if (a[11:5] == `MB_OFF_REGION0 >> 5 && a[1:0] == 2'h0 && 32'(a[4:2]) < NUM_BANKS)
      decode_off = {1'b1, a[4:2]};
  endfunction

  // Byte-lane merge of a register write
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] k;
    k = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    merge = (o & ~k) | (d & k);
  endfunction

  // Handshakes and decode
  assign awready = !aw_have_q && !bvalid_q;
  assign wready  = !w_have_q && !bvalid_q;
  assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
  assign arready = !rvalid_q;
  assign rd_fire = arvalid && arready;
  assign wr_code = decode_off(aw_addr_q);
  assign rd_code = decode_off(araddr);
  assign wmask   = merge(32'h0, w_data_q, w_strb_q);
  assign bvalid  = bvalid_q;
  assign bresp   = bresp_q;
  assign rvalid  = rvalid_q;
  assign rresp   = rresp_q;
  assign rdata   = rdata_q;

  // Address and data may arrive in either order
  always_ff @(posedge aclk)
    if (!aresetn)
    begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `MB_RESP_OKAY;
      aw_addr_q <= 12'h000;
      w_data_q  <= 32'h0;
      w_strb_q  <= 4'h0;
    end
    else
    begin
      if (awvalid && awready)
      begin
        aw_have_q <= 1'b1;
        aw_addr_q <= awaddr;
      end
      if (wvalid && wready)
      begin
        w_have_q <= 1'b1;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      if (wr_fire)
      begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= (wr_code == 4'hf) ? `MB_RESP_SLVERR : `MB_RESP_OKAY;
      end
      else if (bvalid_q && bready)
        bvalid_q <= 1'b0;
    end

  // Read data select; reserved bits read as zero
  always_comb
  begin
    rd_mux = 32'h0;
    case (rd_code)
      4'h0:    rd_mux = {25'h0, mode_q};
      4'h1:    rd_mux = {23'h0, st_q};
      4'h2:    rd_mux = {24'h0, type_q};
      4'hf:    rd_mux = 32'h0;
      default: rd_mux = region_q[rd_code[2:0]];
    endcase
  end

  // Read answer one cycle after the address is taken
  always_ff @(posedge aclk)
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0;
      rresp_q  <= `MB_RESP_OKAY;
    end
    else if (rd_fire)
    begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_mux;
      rresp_q  <= (rd_code == 4'hf) ? `MB_RESP_SLVERR : `MB_RESP_OKAY;
    end
    else if (rready)
      rvalid_q <= 1'b0;

  // Merged write words for the narrow registers
  logic [31:0] mode_wr, type_wr;
  assign mode_wr = merge({25'h0, mode_q}, w_data_q, w_strb_q);
  assign type_wr = merge({24'h0, type_q}, w_data_q, w_strb_q);

  // Mode and bank type registers
  always_ff @(posedge aclk)
    if (!aresetn)
    begin
      mode_q <= `MB_MODE_RESET;
      type_q <= `MB_TYPE_RESET;
    end
    else if (wr_fire)
    begin
      if (wr_code == 4'h0)
        mode_q <= mode_wr[`MB_MODE_W-1:0];
      if (wr_code == 4'h2)
        type_q <= type_wr[7:0];
    end

  // Region registers, relax and external negate reset to one
  for (genvar b = 0; b < NUM_BANKS; b++)
  begin : g_region
    always_ff @(posedge aclk)
      if (!aresetn)
        region_q[b] <= `MB_REGION_RESET;
      else if (wr_fire && wr_code == {1'b1, 3'(b)})
        region_q[b] <= merge(region_q[b], w_data_q, w_strb_q);
  end

  // External strobes: two flops, then optional extra stages
  logic [1:0] as_sync_q, ts_sync_q;
  logic       as_x1_q, as_x2_q, ts_x1_q, as_armed_q, ts_armed_q;
  logic       as_use, ts_use, as_start, ts_start;
  always_ff @(posedge aclk)
    if (!aresetn)
    begin
      as_sync_q <= 2'h3;
      ts_sync_q <= 2'h3;
      as_x1_q   <= 1'b1;
      as_x2_q   <= 1'b1;
      ts_x1_q   <= 1'b1;
    end
    else
    begin
      as_sync_q <= {as_sync_q[0], address_strobe_n};
      ts_sync_q <= {ts_sync_q[0], transfer_start_n};
      as_x1_q   <= as_sync_q[1];
      as_x2_q   <= as_x1_q;
      ts_x1_q   <= ts_sync_q[1];
    end

  // Mode 00 resynchronises the strobe two more cycles
  // Mode 01 uses the strobe straight from the pin flops
  // Mode 11 adds one cycle against mode 01
  assign as_use = !m.ext_master_sync ? (m.fast_sync_bus_mode ? as_sync_q[1] : as_x2_q) : as_x1_q;
  assign ts_use = m.transfer_start_delay_sample ? ts_x1_q : ts_sync_q[1];

  // Cycle state and snapshot
  cyc_state_e  state_q, state_d;
  mem_req_s    cyc_cmd_q, new_cmd;
  src_e        cyc_src_q, new_src;
  mode_s       cyc_mode_q;
  logic [31:0] cyc_rg_q, new_rg;
  logic [2:0]  cyc_bank_q, hit_idx;
  logic        cyc_dram_q;
  logic [NUM_BANKS-1:0] hit_vec;
  logic        idle, start_any, new_hit, wp_block, go, abort, relax_new, feat_new;

  assign idle      = (state_q == ST_IDLE);
  assign int_ready = idle;
  assign as_start  = idle && !int_req && !as_use && as_armed_q;
  assign ts_start  = idle && !int_req && !as_start && !ts_use && ts_armed_q;
  assign start_any = (idle && int_req) || as_start || ts_start;
  assign new_src   = int_req ? SRC_INT : (as_start ? SRC_STROBE : SRC_TSTART);
  assign new_cmd   = int_req ? int_cmd : ext_cmd;

  // Strobe is served once per assertion
  always_ff @(posedge aclk)
    if (!aresetn)
    begin
      as_armed_q <= 1'b0;
      ts_armed_q <= 1'b0;
    end
    else
    begin
      as_armed_q <= as_use || (as_armed_q && !as_start);
      ts_armed_q <= ts_use || (ts_armed_q && !ts_start);
    end

  for (genvar b = 0; b < NUM_BANKS; b++)
  begin : g_hit
    assign hit_vec[b] = region_q[b][`MB_RG_VALID]
      && region_q[b][`MB_RG_BASE_MSB:`MB_RG_BASE_LSB] == new_cmd.addr[31:11]
      && region_q[b][`MB_RG_FC_MSB:`MB_RG_FC_LSB] == new_cmd.fc
      && !(m.cpu_space_select_suppress && new_cmd.fc == `MB_CPU_SPACE_FC);
  end

  // Lowest matching bank wins
  always_comb
  begin
    hit_idx = 3'h0;
    for (int i = NUM_BANKS - 1; i >= 0; i--)
      if (hit_vec[i])
        hit_idx = 3'(i);
  end

  // Protected write aborts without strobe or ack
  assign new_rg    = region_q[hit_idx];
  assign new_hit   = |hit_vec;
  assign wp_block  = new_hit && new_cmd.write && new_rg[`MB_RG_WPROT];
  assign go        = start_any && new_hit && !wp_block;
  assign abort     = start_any && !go;
  assign feat_new  = (new_src == SRC_INT) || (new_src == SRC_STROBE && m.ext_master_sync);
  assign relax_new = (new_src != SRC_TSTART) && new_rg[`MB_RG_RELAX] && feat_new;

  // Cycle-time terms from the snapshot
  logic cyc_feat, early, chk, gen_par, hold_async, end_exit, is_end, sel_on, dram_col;
  assign cyc_feat = (cyc_src_q == SRC_INT) || (cyc_src_q == SRC_STROBE && cyc_mode_q.ext_master_sync);
  assign early    = (cyc_src_q == SRC_TSTART) ? cyc_rg_q[`MB_RG_ENEG_EXT] : cyc_rg_q[`MB_RG_ENEG_INT] && cyc_feat;
  // No parity for the strobe master outside sync mode
  assign gen_par  = (cyc_src_q != SRC_STROBE) || cyc_mode_q.ext_master_sync;
  assign chk      = !cyc_cmd_q.write && cyc_rg_q[`MB_RG_PARITY_CHECK_ENABLE] && gen_par;
  // Async strobe master holds the end until its strobe negates
  assign hold_async = (cyc_src_q == SRC_STROBE) && !cyc_mode_q.ext_master_sync;
  assign end_exit = !hold_async || as_use;
  assign is_end   = (state_q == ST_END);

  // Settings captured when the access starts
  always_ff @(posedge aclk)
    if (!aresetn)
    begin
      cyc_cmd_q  <= '0;
      cyc_src_q  <= SRC_INT;
      cyc_mode_q <= mode_s'(`MB_MODE_RESET);
      cyc_rg_q   <= 32'h0;
      cyc_bank_q <= 3'h0;
      cyc_dram_q <= 1'b0;
    end
    else if (go)
    begin
      cyc_cmd_q  <= new_cmd;
      cyc_src_q  <= new_src;
      cyc_mode_q <= m;
      cyc_rg_q   <= new_rg;
      cyc_bank_q <= hit_idx;
      cyc_dram_q <= type_q[hit_idx];
    end

  // Cycle sequence
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:  if (go) state_d = relax_new ? ST_RELAX : ST_ROW;
      ST_RELAX: state_d = ST_ROW;
      ST_ROW:   state_d = cyc_dram_q ? ST_COL : ST_END;
      ST_COL:   state_d = ST_END;
      // Sync cycles end on the next clock edge
      ST_END:   if (end_exit) state_d = ST_IDLE;
      default:  state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge aclk)
    if (!aresetn)
      state_q <= ST_IDLE;
    else
      state_q <= state_d;

  // Parity for write data and read check
  logic [3:0] wr_par, rd_par;
  logic       parity_error_output_evt;
  lane_parity #(.LANES(4)) u_wr_par
  (
    .data (cyc_cmd_q.wdata),
    .odd  (cyc_mode_q.odd_parity_select),
    .par  (wr_par)
  );
  // Same polarity for generation and check
  lane_parity #(.LANES(4)) u_rd_par
  (
    .data (mem_rdata),
    .odd  (cyc_mode_q.odd_parity_select),
    .par  (rd_par)
  );
  assign parity_error_output_evt = is_end && chk && (rd_par != mem_rpar);

  // Memory pin values
  mem_pins_s pins_d;
  assign sel_on   = (state_q == ST_ROW || state_q == ST_COL || is_end)
                    && !(is_end && early && cyc_cmd_q.write && !cyc_dram_q);
  // Mux low only for the column part of a DRAM cycle
  assign dram_col = cyc_dram_q && (state_q == ST_COL || is_end);
  assign pins_d.sel_n           = ~(sel_on ? (8'h01 << cyc_bank_q) : 8'h00);
  assign pins_d.col_strobe_n    = !dram_col;
  assign pins_d.data_size_ack_n = !(is_end && cyc_src_q != SRC_TSTART);
  assign pins_d.transfer_ack_n  = !(is_end && cyc_src_q == SRC_TSTART);
  assign pins_d.row_col_mux_control = !dram_col;
  // Row address on the bus only with internal muxing
  assign pins_d.addr = (cyc_dram_q && cyc_mode_q.global_row_col_mux_enable && !dram_col)
                       ? (cyc_cmd_q.addr >> ROW_SHIFT) : cyc_cmd_q.addr;
  assign pins_d.wpar = (gen_par && cyc_cmd_q.write) ? wr_par : 4'h0;

  assign st_set = {abort && wp_block, parity_error_output_evt ? (8'h01 << cyc_bank_q) : 8'h00};
  assign st_clr = (wr_fire && wr_code == 4'h1) ? wmask[`MB_ST_W-1:0] : '0;
  // Set wins over a clear in the same cycle
  assign st_d   = (st_q & ~st_clr) | st_set;

  // Status has no interrupt output
  // Registered outputs and status
  always_ff @(posedge aclk)
    if (!aresetn)
    begin
      mem                 <= '{sel_n: 8'hff, default: '1};
      st_q                <= `MB_STATUS_RESET;
      parity_error_output <= 1'b0;
      int_done            <= 1'b0;
      int_bus_error       <= 1'b0;
      int_rdata           <= 32'h0;
    end
    else
    begin
      mem  <= pins_d;
      st_q <= st_d;
      parity_error_output <= |st_d[7:0];
      int_done <= (abort && new_src == SRC_INT) || (is_end && end_exit && cyc_src_q == SRC_INT);
      // Bus error only for internal master, never external
      int_bus_error <= (abort && new_src == SRC_INT)
                       || (parity_error_output_evt && cyc_src_q == SRC_INT && cyc_mode_q.parity_bus_error_enable);
      if (is_end && cyc_src_q == SRC_INT && !cyc_cmd_q.write)
        int_rdata <= mem_rdata;
    end

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_SEL_NEEDS_VALID: assert property (sel_on |-> cyc_rg_q[`MB_RG_VALID])
    else $error("strobe on an invalid bank");
  AST_NO_CPU_SPACE: assert property ((state_q == ST_ROW) |->
    !(cyc_mode_q.cpu_space_select_suppress && cyc_cmd_q.fc == `MB_CPU_SPACE_FC))
    else $error("strobe on suppressed cpu space");
  AST_WP_NO_STROBE: assert property ((abort && wp_block) |=> idle ##1 mem.sel_n == 8'hff)
    else $error("protected write drove a strobe");
  AST_WRITE_PROTECT_ERROR_FLAG_SET: assert property ((abort && wp_block) |=> st_q[`MB_ST_WRITE_PROTECT_ERROR_FLAG])
    else $error("protect flag not set");
  AST_PARITY_ERROR_OUTPUT_PIN: assert property ((st_q[7:0] != 8'h00) |-> parity_error_output)
    else $error("parity pin low with flags set");
  AST_EXT_NO_BUS_ERROR_SIGNAL: assert property ((parity_error_output_evt && cyc_src_q != SRC_INT) |=> !int_bus_error)
    else $error("external parity error raised bus error");
  AST_PARITY_BUS_ERROR_ENABLE_BUS_ERROR_SIGNAL: assert property ((parity_error_output_evt && cyc_src_q == SRC_INT
    && cyc_mode_q.parity_bus_error_enable) |=> int_bus_error && int_done)
    else $error("internal parity error without bus error");
  AST_FLAG_HOLD: assert property ((st_clr == '0 && st_set == '0) |=> st_q == $past(st_q))
    else $error("status changed without cause");
  AST_MUX_IDLE_HIGH: assert property ((idle && !$past(idle)) |=> mem.row_col_mux_control)
    else $error("mux control low after cycle end");
  AST_SYNC_END_ONE: assert property ((is_end && !hold_async) |=> idle ##1 mem.data_size_ack_n)
    else $error("synchronous cycle end not one clock");
  AST_NO_ASYNC_PARITY: assert property ((cyc_src_q == SRC_STROBE
    && !cyc_mode_q.ext_master_sync && is_end) |-> !parity_error_output_evt)
    else $error("parity checked for async master");

  COV_DRAM_CYCLE: cover property (state_q == ST_ROW ##1 state_q == ST_COL ##1 is_end);
  COV_PARITY_ERR: cover property (parity_error_output_evt);
  COV_WP_ERR: cover property (abort && wp_block);
  COV_RELAX: cover property (state_q == ST_RELAX ##1 state_q == ST_ROW);
endmodule

// ==== rtl/mem_bank_map.svh ====
// Register offsets, field positions and reset values of the bank controller
// Assumes inclusion by bare name from the controller and its package users
`ifndef MEM_BANK_MAP_SVH
`define MEM_BANK_MAP_SVH
// Byte offsets on the register bus
`define MB_OFF_MODE      12'h000
`define MB_OFF_STATUS    12'h004
`define MB_OFF_TYPE      12'h008
`define MB_OFF_REGION0   12'h040
// Region decode register fields
`define MB_RG_VALID      0
`define MB_RG_WPROT      1
`define MB_RG_PARITY_CHECK_ENABLE      2
`define MB_RG_ENEG_INT   3
`define MB_RG_ENEG_EXT   4
`define MB_RG_RELAX      6
`define MB_RG_FC_LSB     7
`define MB_RG_FC_MSB     10
`define MB_RG_BASE_LSB   11
`define MB_RG_BASE_MSB   31
// Status fields and width
`define MB_ST_WRITE_PROTECT_ERROR_FLAG       8
`define MB_ST_W          9
// Mode register width
`define MB_MODE_W        7
// Reset values
`define MB_MODE_RESET    7'h00
`define MB_REGION_RESET  32'h00000050
`define MB_TYPE_RESET    8'h00
`define MB_STATUS_RESET  9'h000
// Function code of a CPU-space access
`define MB_CPU_SPACE_FC  4'h7
// Bus responses
`define MB_RESP_OKAY     2'h0
`define MB_RESP_SLVERR   2'h2
`endif

// ==== rtl/mem_bank_pkg.sv ====
// Types shared by the bank controller and its bench
// Assumes nothing beyond the map header for numbers
package mem_bank_pkg;
  // One-hot bus cycle states
  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_RELAX = 5'h02,
    ST_ROW   = 5'h04,
    ST_COL   = 5'h08,
    ST_END   = 5'h10
  } cyc_state_e;
  // Owner of the current cycle
  typedef enum logic [1:0] {
    SRC_INT    = 2'h0,
    SRC_STROBE = 2'h1,
    SRC_TSTART = 2'h2
  } src_e;
  // Global mode bits, sync in bit 0
  typedef struct packed {
    logic global_row_col_mux_enable;
    logic cpu_space_select_suppress;
    logic transfer_start_delay_sample;
    logic parity_bus_error_enable;
    logic odd_parity_select;
    logic fast_sync_bus_mode;
    logic ext_master_sync;
  } mode_s;
  // One access request from a master
  typedef struct packed {
    logic [31:0] addr;
    logic [3:0]  fc;
    logic        write;
    logic [31:0] wdata;
  } mem_req_s;
  // Memory side strobes and address
  typedef struct packed {
    logic [7:0]  sel_n;
    logic        col_strobe_n;
    logic        data_size_ack_n;
    logic        transfer_ack_n;
    logic        row_col_mux_control;
    logic [31:0] addr;
    logic [3:0]  wpar;
  } mem_pins_s;
endpackage

// ==== rtl/lane_parity.sv ====
// Per-byte-lane parity generator, used for write data and read checks
// Assumes byte lanes with lane 0 in the low bits
`timescale 1ns/1ps
module lane_parity
#(
  parameter int LANES = 4
)
(
  // Data and polarity
  input  logic [8*LANES-1:0] data,
  input  logic               odd,
  // Parity per lane
  output logic [LANES-1:0]   par
);
  if (LANES < 1)
  begin : g_bad
    $error("lane_parity needs at least one lane");
  end

  // Even parity when odd is low, odd parity when high
  function automatic logic lane_bit(input logic [7:0] b, input logic o);
    lane_bit = (^b) ^ o;
  endfunction

  // One parity bit for each byte lane
  for (genvar i = 0; i < LANES; i++)
  begin : g_lane
    assign par[i] = lane_bit(data[8*i +: 8], odd);
  end
endmodule

// ==== testbench/bank_mem_model.sv ====
// Memory bank model: answers reads with an address-derived word and lane parity
// Assumes the controller's registered strobes and address bus
`timescale 1ns/1ps
module bank_mem_model
  import mem_bank_pkg::*;
(
  // Controller side
  input  mem_pins_s   mem,
  // Scenario controls
  input  logic        odd,
  input  logic        bad,
  // Read data
  output logic [31:0] mem_rdata,
  output logic [3:0]  mem_rpar
);
  logic [31:0] word;
  logic [3:0]  par;
  logic        hit;
  // Word from address; parity per lane, lane 0 optionally corrupted
  // even or odd parity on every lane
  assign word = {mem.addr[15:0] ^ 16'h5a5a, mem.addr[15:0]};
  assign par  = {^word[31:24], ^word[23:16], ^word[15:8], ^word[7:0]} ^ {4{odd}} ^ {3'h0, bad};
  assign hit  = (mem.sel_n != 8'hff);
  // Deselected bank shows the inverse, never a stale word
  assign mem_rdata = hit ? word : ~word;
  assign mem_rpar  = hit ? par : ~par;
endmodule

// ==== testbench/memory_bank_ctrl_parity_status_tb_top.sv ====
// Bench for the bank controller: AXI4-Lite register tasks, internal and external master cycles
// Assumes the bank model answers reads; bready and rready stay high once raised
`timescale 1ns/1ps
`include "mem_bank_map.svh"
module memory_bank_ctrl_parity_status_tb_top
  import mem_bank_pkg::*;
;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, int_req, awready, wready, bvalid, arready, rvalid;
  logic int_ready, int_done, int_bus_error, parity_error_output, odd, bad, be, as_n, ts_n;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, int_rdata, mem_rdata, d;
  logic [3:0]  wstrb, mem_rpar;
  logic [1:0]  bresp, rresp, r;
  mem_req_s    int_cmd, ext_cmd;
  mem_pins_s   mem;
  int error_cnt, checked, cyc, sel_cnt, s0, mux_cnt, bus_error_signal_cnt, s1;
  memory_bank_ctrl_parity_status dut_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .int_req(int_req), .int_cmd(int_cmd),
    .int_ready(int_ready), .int_done(int_done), .int_bus_error(int_bus_error), .int_rdata(int_rdata),
    .address_strobe_n(as_n), .transfer_start_n(ts_n), .ext_cmd(ext_cmd), .mem_rdata(mem_rdata),
    .mem_rpar(mem_rpar), .mem(mem), .parity_error_output(parity_error_output));
  bank_mem_model mdl_u (.mem(mem), .odd(odd), .bad(bad), .mem_rdata(mem_rdata), .mem_rpar(mem_rpar));
  // Clock at 50 ns
  initial
  begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  // Selected-cycle counter and hang guard
  always @(posedge aclk)
  begin
    if (mem.sel_n !== 8'hff) sel_cnt++;
    if (mem.row_col_mux_control !== 1'b1) mux_cnt++;
    if (int_bus_error) bus_error_signal_cnt++;
    if (++cyc == 20000)
    begin
      error_cnt++;
      summarize();
    end
  end
  task automatic summarize();
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e) begin error_cnt++; $display("[FAIL] %s exp %h got %h", n, e, s); end
  endtask
  // AXI4-Lite write, both channels offered together
  task automatic axw(input logic [11:0] a, input logic [31:0] v);
    awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
  endtask
  task automatic axr(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    v = rdata;
    rs = rresp;
  endtask
  // Internal master cycle; returns bus error and whether any select went low
  task automatic cyc_int(input logic [3:0] fc, input logic w, output logic e, output logic sel);
    int_cmd <= '{addr: 32'h00000120, fc: fc, write: w, wdata: 32'h0f0f3c3c}; int_req <= 1'b1;
    s0 = sel_cnt;
    do @(posedge aclk); while (!int_ready);
    int_req <= 1'b0;
    for (int i = 0; i < 50 && !int_done; i++) @(posedge aclk);
    e = int_bus_error;
    chk("done", 1'b1, int_done);
    repeat (3) @(posedge aclk);
    sel = (sel_cnt != s0);
  endtask
  // External master read: strobe or transfer start held low, then released
  task automatic ext_rd(input logic ts);
    ext_cmd <= '{addr: 32'h00000120, fc: 4'h7, write: 1'b0, wdata: 32'h0};
    if (ts) ts_n <= 1'b0;
    else as_n <= 1'b0;
    repeat (12) @(posedge aclk);
    as_n <= 1'b1;
    ts_n <= 1'b1;
    repeat (8) @(posedge aclk);
  endtask
  initial
  begin
    logic sel;
    aresetn = 1'b0; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0; int_req = 0;
    awaddr = 0; araddr = 0; wdata = 0; wstrb = 4'hf; int_cmd = '0; odd = 0; bad = 0;
    ext_cmd = '0; as_n = 1'b1; ts_n = 1'b1;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axr(`MB_OFF_MODE, d, r); chk("mode", 32'h0, d);
    axr(`MB_OFF_STATUS, d, r); chk("status", 32'h0, d);
    axr(`MB_OFF_REGION0 + 12'h8, d, r); chk("region2", 32'h00000050, d);
    axr(12'h0fc, d, r); chk("unmapped", `MB_RESP_SLVERR, r);
    cyc_int(4'h5, 1'b0, be, sel); chk("invalid sel", 1'b0, sel);
    axw(`MB_OFF_REGION0, 32'hfffff285);
    axr(`MB_OFF_REGION0, d, r); chk("region0", 32'hfffff285, d);
    axw(`MB_OFF_REGION0, 32'h00000285);
    axw(`MB_OFF_MODE, 32'h08);
    cyc_int(4'h5, 1'b0, be, sel); chk("good err", 1'b0, be);
    chk("rdata", 32'h5b7a0120, int_rdata);
    chk("good sel", 1'b1, sel);
    bad <= 1'b1;
    cyc_int(4'h5, 1'b0, be, sel); chk("bad err", 1'b1, be);
    axr(`MB_OFF_STATUS, d, r); chk("flag0", 32'h001, d);
    chk("pin", 1'b1, parity_error_output);
    axw(`MB_OFF_STATUS, 32'h0);
    axr(`MB_OFF_STATUS, d, r); chk("w0 keeps", 32'h001, d);
    axw(`MB_OFF_STATUS, 32'h1);
    axr(`MB_OFF_STATUS, d, r); chk("w1 clears", 32'h0, d);
    chk("pin off", 1'b0, parity_error_output);
    bad <= 1'b0;
    axw(`MB_OFF_MODE, 32'h0c);
    cyc_int(4'h5, 1'b0, be, sel); chk("odd err", 1'b1, be);
    odd <= 1'b1;
    cyc_int(4'h5, 1'b0, be, sel); chk("odd ok", 1'b0, be);
    odd <= 1'b0;
    axw(`MB_OFF_STATUS, 32'h1ff);
    axw(`MB_OFF_REGION0, 32'h00000385);
    axw(`MB_OFF_MODE, 32'h28);
    cyc_int(4'h7, 1'b0, be, sel); chk("cpu space", 1'b0, sel);
    axw(`MB_OFF_MODE, 32'h08);
    cyc_int(4'h7, 1'b0, be, sel); chk("cpu allowed", 1'b1, sel);
    axw(`MB_OFF_REGION0, 32'h00000387);
    cyc_int(4'h7, 1'b1, be, sel); chk("wp sel", 1'b0, sel);
    chk("wp err", 1'b1, be);
    axr(`MB_OFF_STATUS, d, r); chk("write_protect_error_flag", 32'h100, d);
    // DRAM bank with internal row and column muxing
    axw(`MB_OFF_STATUS, 32'h1ff);
    axw(`MB_OFF_TYPE, 32'h01);
    axw(`MB_OFF_MODE, 32'h40);
    s1 = mux_cnt;
    cyc_int(4'h7, 1'b0, be, sel); chk("dram sel", 1'b1, sel);
    chk("dram rdata", 32'h5b7a0120, int_rdata);
    chk("mux low", 1'b1, mux_cnt != s1);
    chk("mux back", 1'b1, mem.row_col_mux_control);
    axw(`MB_OFF_TYPE, 32'h00);
    // Strobe master, sync mode: parity flag, no bus error
    axw(`MB_OFF_MODE, 32'h0b);
    bad <= 1'b1;
    s0 = sel_cnt;
    s1 = bus_error_signal_cnt;
    ext_rd(1'b0); chk("ext sync sel", 1'b1, sel_cnt != s0);
    chk("ext bus_error_signal", s1, bus_error_signal_cnt);
    axr(`MB_OFF_STATUS, d, r); chk("ext flag", 32'h001, d);
    chk("ext pin", 1'b1, parity_error_output);
    // Strobe master, modes 00 and 01: no parity support
    axw(`MB_OFF_STATUS, 32'h1ff);
    axw(`MB_OFF_MODE, 32'h08);
    s0 = sel_cnt;
    ext_rd(1'b0); chk("ext async sel", 1'b1, sel_cnt != s0);
    axr(`MB_OFF_STATUS, d, r); chk("async no parity", 32'h0, d);
    axw(`MB_OFF_MODE, 32'h0a);
    s0 = sel_cnt;
    ext_rd(1'b0); chk("ext fast sel", 1'b1, sel_cnt != s0);
    axr(`MB_OFF_STATUS, d, r); chk("fast no parity", 32'h0, d);
    // Transfer-start master with delayed sampling
    axw(`MB_OFF_MODE, 32'h18);
    s0 = sel_cnt;
    s1 = bus_error_signal_cnt;
    ext_rd(1'b1); chk("ts sel", 1'b1, sel_cnt != s0);
    chk("ts bus_error_signal", s1, bus_error_signal_cnt);
    axr(`MB_OFF_STATUS, d, r); chk("ts flag", 32'h001, d);
    chk("ts pin", 1'b1, parity_error_output);
    // Mid-run reset clears flags and pin
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("reset pin", 1'b0, parity_error_output);
    axr(`MB_OFF_STATUS, d, r); chk("reset status", 32'h0, d);
    summarize();
  end
endmodule
